// ==== sirc_params.svh ====
// constants of the sdram init and refresh controller: offsets, fields, resets, levels
// assumes a word-addressed avalon-mm slave and a 13-bit memory address bus
// Operation
// RL1: lower-two-byte main config write starts init; second config write too in low-power mode
// RL2: main-config-triggered init first precharges all banks if any bank is open
// RL3: drive clock enable high, then nops until eight refresh intervals elapse
// RL4: after the nop wait issue precharge-all with address bit 10 high
// RL5: then issue exactly eight auto refresh commands back to back
// RL6: low-power mode only: extended mode load with partial refresh select in bits 2:0
// RL7: mode register load for both types, bits 9:7 and bit 3 zero
// RL8: mode load bits 6:4 carry the cas latency field value
// RL9: mode load bits 2:0 are 2h for wide bus, 3h for narrow bus
// RL10: finish with one auto refresh cycle, then go idle awaiting accesses
// RL11: software enters self-refresh before changing the memory clock frequency
// RL12: software order: enable, timings, refresh period, then main config write
// RL13: upper-byte-only main config write must not restart initialization
// RL14: every auto refresh cycle is precharge-all followed by refresh
// RL15: refresh always runs at the programmed rate, no disable, memory or not
// RL16: 13-bit down-counting interval counter and 4-bit backlog counter
// RL17: with interface enabled, a refresh period write loads the interval counter
// RL18: at zero reload the interval counter and bump backlog unless saturated
// RL19: backlog drops by one per refresh cycle, saturating at 0 and 15
// RL20: backlog 1-3: refresh only with no requests pending and no bank open
// RL21: backlog 4-7: refresh with no requests pending, banks open or not
// RL22: backlog 8-11: refresh after current access unless reads are pending
// RL23: backlog 12-15: refresh repeatedly until back to 4-7, holding new accesses
// RL24: a configuration write abandons current activity and restarts initialization
// RL25: hold memory accesses until init reaches idle; registers stay serviceable
`ifndef SIRC_PARAMS_SVH
`define SIRC_PARAMS_SVH

// ----------------------------------------------------------------
// register word offsets
// ----------------------------------------------------------------
`define SIRC_OFS_MAIN    3'h0
`define SIRC_OFS_RFC     3'h1
`define SIRC_OFS_TIM1    3'h2
`define SIRC_OFS_TIM2    3'h3
`define SIRC_OFS_CFG2    3'h4
`define SIRC_OFS_STAT    3'h5

// ----------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------
`define SIRC_MAIN_RST    32'h0001_0600
`define SIRC_MAIN_MASK   32'h0003_4e00
`define SIRC_RFC_RST     32'h0000_0100
`define SIRC_RFC_MASK    32'hc000_1fff
`define SIRC_TIM1_RST    32'h0000_0083
`define SIRC_TIM1_MASK   32'h0000_0fff
`define SIRC_TIM2_RST    32'h0000_0000
`define SIRC_TIM2_MASK   32'hffff_ffff
`define SIRC_CFG2_RST    32'h0000_0000
`define SIRC_CFG2_MASK   32'h0000_0007

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SIRC_CL_HI       11
`define SIRC_CL_LO       9
`define SIRC_NM_BIT      14
`define SIRC_EN_BIT      16
`define SIRC_LPEN_BIT    17
`define SIRC_PER_HI      12
`define SIRC_PER_LO      0
`define SIRC_SRSEL_BIT   30
`define SIRC_LPREQ_BIT   31
`define SIRC_TRP_HI      3
`define SIRC_TRP_LO      0
`define SIRC_TRFC_HI     11
`define SIRC_TRFC_LO     4
`define SIRC_PARTIAL_REFRESH_SELECT_HI     2
`define SIRC_PARTIAL_REFRESH_SELECT_LO     0
`define SIRC_ST_BL_HI    3
`define SIRC_ST_BL_LO    0
`define SIRC_ST_BUSY     8
`define SIRC_ST_MUST     9
`define SIRC_ST_ALLOW    10

// ----------------------------------------------------------------
// sequencing counts and urgency levels
// ----------------------------------------------------------------
`define SIRC_AW          13
`define SIRC_A10         10
`define SIRC_INIT_LAST   4'h7
`define SIRC_TMRD_CYC    8'h02
`define SIRC_BL_WIDE     3'h2
`define SIRC_BL_NARROW   3'h3
`define SIRC_BA_EXT      2'h2
`define SIRC_BA_STD      2'h0
`define SIRC_LVL_RELEASE 4'h4
`define SIRC_LVL_NEED    4'h8
`define SIRC_LVL_MUST    4'hc
`define SIRC_BL_MAX      4'hf
`define SIRC_BL_MIN      4'h0

`endif

// ==== sirc_pkg.sv ====
// types shared by the sdram init and refresh controller
// assumes sirc_params.svh for widths
`include "sirc_params.svh"
package sirc_pkg;

	typedef enum logic [3:0] {
		S_IDLE = 4'b0000,
		S_PRE0 = 4'b0001,
		S_NOPW = 4'b0010,
		S_PRE1 = 4'b0011,
		S_AREF = 4'b0100,
		S_EMRS = 4'b0101,
		S_MRS  = 4'b0110,
		S_FPRE = 4'b0111,
		S_FREF = 4'b1000,
		S_RPRE = 4'b1001,
		S_RREF = 4'b1010
	} sirc_state_t;

	// codes are {cs_n, ras_n, cas_n, we_n}
	typedef enum logic [3:0] {
		CMD_LMR = 4'b0000,
		CMD_REF = 4'b0001,
		CMD_PRE = 4'b0010,
		CMD_NOP = 4'b0111
	} sirc_cmd_t;

	typedef struct packed {
		logic                  waitreq;
		logic [31:0]           readdata;
		logic [31:0]           main;
		logic [31:0]           rfc;
		logic [31:0]           tim1;
		logic [31:0]           tim2;
		logic [31:0]           cfg2;
		sirc_state_t           state;
		logic [7:0]            gap;
		logic [3:0]            cnt;
		logic                  trig_main;
		logic                  must;
		logic                  allow;
	} sirc_top_st_t;

	typedef struct packed {
		logic [12:0]           cnt;
		logic [3:0]            backlog;
		logic                  expire;
	} sirc_tmr_st_t;

	typedef struct packed {
		logic                  cs_n;
		logic                  ras_n;
		logic                  cas_n;
		logic                  we_n;
		logic [12:0]           addr;
		logic [1:0]            ba;
		logic                  cke;
	} sirc_drv_st_t;

endpackage

// ==== sirc_refresh_timer.sv ====
// refresh interval counter and saturating backlog counter
// assumes load and done are single-cycle pulses: load from a register write, done from the sequencer
`timescale 1ns/1ps
`include "sirc_params.svh"
module sirc_refresh_timer
	import sirc_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic        load,
	input  wire logic [12:0] load_value,
	input  wire logic [12:0] period,
	input  wire logic        done,
	output logic      [3:0]  backlog,
	output logic             expire
);

	sirc_tmr_st_t st;
	sirc_tmr_st_t next_st;
	logic         inc;

	// ----------------------------------------------------------------
	// counting
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.expire = 1'b0;
		inc = 1'b0;
		if (load) begin
			next_st.cnt = load_value; // RL17
		end else if (st.cnt == 13'h0000) begin
			next_st.cnt = period; // RL18
			next_st.expire = 1'b1;
			inc = 1'b1;
		end else begin
			next_st.cnt = st.cnt - 13'h0001; // RL16
		end
		// simultaneous bump and drop cancel out
		if (inc && !done && st.backlog != `SIRC_BL_MAX) begin
			next_st.backlog = st.backlog + 4'h1; // RL18
		end else if (done && !inc && st.backlog != `SIRC_BL_MIN) begin
			next_st.backlog = st.backlog - 4'h1; // RL19
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign backlog = st.backlog;
	assign expire  = st.expire;

endmodule

// ==== sirc_cmd_drive.sv ====
// output register stage for the sdram command, address and clock enable pins
// assumes one command per cycle from the sequencer, nop otherwise
`timescale 1ns/1ps
`include "sirc_params.svh"
module sirc_cmd_drive
	import sirc_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        nrst,
	input  sirc_cmd_t        cmd,
	input  wire logic [12:0] addr,
	input  wire logic [1:0]  ba,
	input  wire logic        cke_on,
	output logic             mem_cs_n,
	output logic             mem_ras_n,
	output logic             mem_cas_n,
	output logic             mem_we_n,
	output logic      [12:0] memory_address_pins,
	output logic      [1:0]  memory_bank_pins,
	output logic             memory_clock_enable_pin
);

	sirc_drv_st_t st;
	sirc_drv_st_t next_st;

	always_comb begin
		next_st = st;
		{next_st.cs_n, next_st.ras_n, next_st.cas_n, next_st.we_n} = cmd;
		next_st.addr = addr;
		next_st.ba = ba;
		// no low-power exit logic here, so enable only ever rises
		next_st.cke = st.cke | cke_on; // RL3
	end

	// deselected with clock enable low until the sequencer starts
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			st <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
				addr: 13'h0000, ba: 2'h0, cke: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	assign mem_cs_n                = st.cs_n;
	assign mem_ras_n               = st.ras_n;
	assign mem_cas_n               = st.cas_n;
	assign mem_we_n                = st.we_n;
	assign memory_address_pins     = st.addr;
	assign memory_bank_pins        = st.ba;
	assign memory_clock_enable_pin = st.cke;

endmodule

// ==== sirc_ctrl.sv ====
// sdram init sequencer and refresh scheduler with avalon-mm register slave
// assumes an external access sequencer reports busy, pending and open-bank levels
`timescale 1ns/1ps
`include "sirc_params.svh"
module sirc_ctrl
	import sirc_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic [2:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	input  wire logic        access_busy,
	input  wire logic        req_pending,
	input  wire logic        rd_pending,
	input  wire logic        any_bank_open,
	output logic             access_allow,
	output logic             mem_cs_n,
	output logic             mem_ras_n,
	output logic             mem_cas_n,
	output logic             mem_we_n,
	output logic      [12:0] memory_address_pins,
	output logic      [1:0]  memory_bank_pins,
	output logic             memory_clock_enable_pin
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	sirc_top_st_t st;
	sirc_top_st_t next_st;

	sirc_cmd_t    cmd_c;
	logic [12:0]  addr_c;
	logic [1:0]   ba_c;
	logic         cke_on;
	logic         ref_done;

	logic [31:0]  be_mask;
	logic [31:0]  w_bits;
	logic [31:0]  main_new;
	logic [31:0]  rfc_new;
	logic [31:0]  tim1_new;
	logic [31:0]  tim2_new;
	logic [31:0]  cfg2_new;
	logic [31:0]  rd_data;

	logic         wr_fire;
	logic         trig_main_c;
	logic         trig_cfg2_c;
	logic         trig;
	logic         tmr_load;
	logic         ref_want;

	logic [3:0]   backlog;
	logic         tmr_expire;

	logic [7:0]   t_rp;
	logic [7:0]   t_rfc;
	logic         low_power_request;
	logic         narrow;
	logic [2:0]   cas_lat;
	logic [2:0]   partial_refresh_select;

	// ----------------------------------------------------------------
	// byte lane merge
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : lane
			assign be_mask[8*g+7:8*g] = {8{byteenable[g]}};
		end
	endgenerate

	assign w_bits   = writedata & be_mask;
	assign main_new = ((st.main & ~be_mask) | w_bits) & `SIRC_MAIN_MASK;
	assign rfc_new  = ((st.rfc  & ~be_mask) | w_bits) & `SIRC_RFC_MASK;
	assign tim1_new = ((st.tim1 & ~be_mask) | w_bits) & `SIRC_TIM1_MASK;
	assign tim2_new = ((st.tim2 & ~be_mask) | w_bits) & `SIRC_TIM2_MASK;
	assign cfg2_new = ((st.cfg2 & ~be_mask) | w_bits) & `SIRC_CFG2_MASK;

	// a write takes effect in the single cycle waitrequest is low
	assign wr_fire = write && !st.waitreq;

	// ----------------------------------------------------------------
	// field views
	// ----------------------------------------------------------------
	assign t_rp    = {4'h0, st.tim1[`SIRC_TRP_HI:`SIRC_TRP_LO]};
	assign t_rfc   = st.tim1[`SIRC_TRFC_HI:`SIRC_TRFC_LO];
	assign low_power_request = st.main[`SIRC_EN_BIT] & st.main[`SIRC_LPEN_BIT];
	assign narrow  = st.main[`SIRC_NM_BIT];
	assign cas_lat = st.main[`SIRC_CL_HI:`SIRC_CL_LO];
	assign partial_refresh_select    = st.cfg2[`SIRC_PARTIAL_REFRESH_SELECT_HI:`SIRC_PARTIAL_REFRESH_SELECT_LO];

	// ----------------------------------------------------------------
	// init triggers and interval counter load
	// ----------------------------------------------------------------
	// upper-byte writes to main config leave the sequence alone
	assign trig_main_c = wr_fire && address == `SIRC_OFS_MAIN
		&& (byteenable[1] || byteenable[0]); // RL1 RL13
	assign trig_cfg2_c = wr_fire && address == `SIRC_OFS_CFG2
		&& (byteenable != 4'h0) && low_power_request; // RL1
	assign trig = trig_main_c || trig_cfg2_c; // RL24

	assign tmr_load = wr_fire && address == `SIRC_OFS_RFC
		&& (byteenable[1] || byteenable[0]) && st.main[`SIRC_EN_BIT]; // RL17

	// ----------------------------------------------------------------
	// refresh urgency
	// ----------------------------------------------------------------
	// no enable term anywhere: refresh keeps going with nothing attached
	always_comb begin
		ref_want = 1'b0; // RL15
		if (st.must) begin
			ref_want = 1'b1; // RL23
		end else if (backlog >= `SIRC_LVL_NEED) begin
			ref_want = !rd_pending; // RL22
		end else if (backlog >= `SIRC_LVL_RELEASE) begin
			ref_want = !req_pending; // RL21
		end else if (backlog != `SIRC_BL_MIN) begin
			ref_want = !req_pending && !any_bank_open; // RL20
		end
	end

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	always_comb begin
		rd_data = 32'h0000_0000;
		case (address)
			`SIRC_OFS_MAIN: begin
				rd_data = st.main;
			end
			`SIRC_OFS_RFC: begin
				rd_data = st.rfc;
			end
			`SIRC_OFS_TIM1: begin
				rd_data = st.tim1;
			end
			`SIRC_OFS_TIM2: begin
				rd_data = st.tim2;
			end
			`SIRC_OFS_CFG2: begin
				rd_data = st.cfg2;
			end
			`SIRC_OFS_STAT: begin
				rd_data[`SIRC_ST_BL_HI:`SIRC_ST_BL_LO] = backlog;
				rd_data[`SIRC_ST_BUSY] = st.state != S_IDLE;
				rd_data[`SIRC_ST_MUST] = st.must;
				rd_data[`SIRC_ST_ALLOW] = st.allow;
			end
			default: begin
				rd_data = 32'h0000_0000;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		cmd_c = CMD_NOP;
		addr_c = 13'h0000;
		ba_c = `SIRC_BA_STD;
		cke_on = 1'b0;
		ref_done = 1'b0;

		// bus: one wait state, then a single low cycle
		if (st.waitreq && (read || write)) begin
			next_st.waitreq = 1'b0;
			if (read) begin
				next_st.readdata = rd_data;
			end
		end else begin
			next_st.waitreq = 1'b1;
		end

		// registers stay writable whatever the sequencer is doing
		if (wr_fire) begin // RL25
			case (address)
				`SIRC_OFS_MAIN: begin
					next_st.main = main_new;
				end
				`SIRC_OFS_RFC: begin
					next_st.rfc = rfc_new;
				end
				`SIRC_OFS_TIM1: begin
					next_st.tim1 = tim1_new;
				end
				`SIRC_OFS_TIM2: begin
					next_st.tim2 = tim2_new;
				end
				`SIRC_OFS_CFG2: begin
					next_st.cfg2 = cfg2_new;
				end
				default: begin
					next_st.main = st.main;
				end
			endcase
		end

		// hysteresis: stay urgent until back down to the release band
		if (backlog >= `SIRC_LVL_MUST) begin
			next_st.must = 1'b1; // RL23
		end else if (backlog < `SIRC_LVL_NEED) begin
			next_st.must = 1'b0; // RL23
		end

		if (st.gap != 8'h00) begin
			next_st.gap = st.gap - 8'h01;
		end else begin
			unique case (st.state)
				S_IDLE: begin
					// only between accesses, so the current one completes first
					if (!access_busy && ref_want) begin
						next_st.state = S_RPRE;
					end
				end
				S_PRE0: begin
					if (st.trig_main && any_bank_open) begin
						cmd_c = CMD_PRE; // RL2
						addr_c[`SIRC_A10] = 1'b1; // RL2
						next_st.gap = t_rp;
					end
					next_st.state = S_NOPW;
					next_st.cnt = 4'h0;
				end
				S_NOPW: begin
					cke_on = 1'b1; // RL3
					if (tmr_expire) begin
						if (st.cnt == `SIRC_INIT_LAST) begin
							next_st.state = S_PRE1; // RL3
							next_st.cnt = 4'h0;
						end else begin
							next_st.cnt = st.cnt + 4'h1; // RL3
						end
					end
				end
				S_PRE1: begin
					cmd_c = CMD_PRE; // RL4
					addr_c[`SIRC_A10] = 1'b1; // RL4
					next_st.gap = t_rp;
					next_st.state = S_AREF;
					next_st.cnt = 4'h0;
				end
				S_AREF: begin
					cmd_c = CMD_REF; // RL5
					next_st.gap = t_rfc;
					if (st.cnt == `SIRC_INIT_LAST) begin
						next_st.state = low_power_request ? S_EMRS : S_MRS; // RL5 RL6
						next_st.cnt = 4'h0;
					end else begin
						next_st.cnt = st.cnt + 4'h1; // RL5
					end
				end
				S_EMRS: begin
					cmd_c = CMD_LMR; // RL6
					ba_c = `SIRC_BA_EXT;
					addr_c[`SIRC_PARTIAL_REFRESH_SELECT_HI:`SIRC_PARTIAL_REFRESH_SELECT_LO] = partial_refresh_select; // RL6
					next_st.gap = `SIRC_TMRD_CYC;
					next_st.state = S_MRS;
				end
				S_MRS: begin
					cmd_c = CMD_LMR; // RL7
					addr_c[6:4] = cas_lat; // RL8
					addr_c[2:0] = narrow ? `SIRC_BL_NARROW : `SIRC_BL_WIDE; // RL9
					next_st.gap = `SIRC_TMRD_CYC;
					next_st.state = S_FPRE;
				end
				S_FPRE, S_RPRE: begin
					cmd_c = CMD_PRE; // RL10 RL14
					addr_c[`SIRC_A10] = 1'b1; // RL14
					next_st.gap = t_rp;
					next_st.state = (st.state == S_FPRE) ? S_FREF : S_RREF;
				end
				S_FREF, S_RREF: begin
					cmd_c = CMD_REF; // RL10 RL14
					ref_done = 1'b1; // RL19
					next_st.gap = t_rfc;
					next_st.state = S_IDLE; // RL10
				end
				default: begin
					next_st.state = S_IDLE;
				end
			endcase
		end

		// a config write drops whatever is running and restarts
		if (trig) begin
			next_st.state = S_PRE0; // RL24
			next_st.gap = 8'h00;
			next_st.cnt = 4'h0;
			next_st.trig_main = trig_main_c; // RL2
		end

		next_st.allow = (next_st.state == S_IDLE) && next_st.gap == 8'h00
			&& !next_st.must; // RL25 RL23
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	// the sequence runs once out of reset
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			st <= '{waitreq: 1'b1, readdata: 32'h0000_0000,
				main: `SIRC_MAIN_RST, rfc: `SIRC_RFC_RST,
				tim1: `SIRC_TIM1_RST, tim2: `SIRC_TIM2_RST,
				cfg2: `SIRC_CFG2_RST, state: S_PRE0, gap: 8'h00,
				cnt: 4'h0, trig_main: 1'b0, must: 1'b0, allow: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	assign readdata     = st.readdata;
	assign waitrequest  = st.waitreq;
	assign access_allow = st.allow;

	// ----------------------------------------------------------------
	// submodules
	// ----------------------------------------------------------------
	sirc_refresh_timer u_timer (
		.clock      (clock),
		.nrst       (nrst),
		.load       (tmr_load),
		.load_value (rfc_new[`SIRC_PER_HI:`SIRC_PER_LO]),
		.period     (st.rfc[`SIRC_PER_HI:`SIRC_PER_LO]),
		.done       (ref_done),
		.backlog    (backlog),
		.expire     (tmr_expire)
	);

	sirc_cmd_drive u_drive (
		.clock                   (clock),
		.nrst                    (nrst),
		.cmd                     (cmd_c),
		.addr                    (addr_c),
		.ba                      (ba_c),
		.cke_on                  (cke_on),
		.mem_cs_n                (mem_cs_n),
		.mem_ras_n               (mem_ras_n),
		.mem_cas_n               (mem_cas_n),
		.mem_we_n                (mem_we_n),
		.memory_address_pins     (memory_address_pins),
		.memory_bank_pins        (memory_bank_pins),
		.memory_clock_enable_pin (memory_clock_enable_pin)
	);

endmodule

// ==== sirc_ctrl_props.sv ====
// checker for sequencer command pins, mode loads and bus answer
// assumes sirc_ctrl port names; bound after the module
`timescale 1ns/1ps
module sirc_ctrl_props
	import sirc_pkg::*;
(
	input wire logic        clock,
	input wire logic        nrst,
	input wire logic [2:0]  address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [3:0]  byteenable,
	input wire logic        waitrequest,
	input wire logic        access_allow,
	input wire logic        mem_cs_n,
	input wire logic        mem_ras_n,
	input wire logic        mem_cas_n,
	input wire logic        mem_we_n,
	input wire logic [12:0] memory_address_pins,
	input wire logic [1:0]  memory_bank_pins,
	input wire logic        memory_clock_enable_pin
);
	logic [3:0]  cmd;
	logic [12:0] a;
	logic        cke;
	logic        busy_cmd;
	assign cmd = {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n};
	assign a = memory_address_pins;
	assign cke = memory_clock_enable_pin;
	assign busy_cmd = cmd inside {CMD_PRE, CMD_REF, CMD_LMR};
	default clocking @(posedge clock);
	endclocking
	default disable iff (!nrst);
	// ----------------------------------------
	// memory command pins
	// ----------------------------------------
	a_pre_all_banks: assert property (cmd == CMD_PRE |-> a[10])
		else $error("precharge without all-bank bit");
	a_cmd_one_cycle: assert property (busy_cmd |=> cmd == CMD_NOP)
		else $error("command not followed by nop");
	a_cke_stays_up: assert property (cke |=> cke)
		else $error("clock enable dropped");
	a_cke_before_ref: assert property (cmd inside {CMD_REF, CMD_LMR} |-> cke)
		else $error("refresh or mode load with clock enable low");
	a_mode_load_fields: assert property (cmd == CMD_LMR && memory_bank_pins == 2'h0
		|-> a[12:7] == 6'h0 && !a[3] && a[6:4] inside {3'h2, 3'h3} && a[2:0] inside {3'h2, 3'h3})
		else $error("mode load fields wrong");
	a_ext_load_fields: assert property (cmd == CMD_LMR && memory_bank_pins == 2'h2 |->
		a[12:3] == 10'h0)
		else $error("extended mode load fields wrong");
	// ----------------------------------------
	// bus answer and access gating
	// ----------------------------------------
	a_bus_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("bus answer late");
	a_cfg_restarts: assert property (write && !waitrequest && address == 3'h0
		&& |byteenable[1:0] |=> ##[0:2] !access_allow)
		else $error("config write did not restart");
	a_allow_no_cmd: assert property (busy_cmd |-> !access_allow)
		else $error("access allowed during command");
	c_ext_load: cover property (cmd == CMD_LMR && memory_bank_pins == 2'h2);
	c_refresh: cover property (cmd == CMD_REF);
	c_upper_write: cover property (write && !waitrequest && byteenable == 4'h4);
endmodule

bind sirc_ctrl sirc_ctrl_props i_sirc_ctrl_props (.clock, .nrst, .address, .read, .write,
	.byteenable, .waitrequest, .access_allow, .mem_cs_n, .mem_ras_n, .mem_cas_n,
	.mem_we_n, .memory_address_pins, .memory_bank_pins, .memory_clock_enable_pin);

// ==== sirc_mem_model.sv ====
// sdram device model: counts commands and keeps mode register images
// assumes command pins registered on the rising clock edge
`timescale 1ns/1ps
module sirc_mem_model
	import sirc_pkg::*;
(
	input wire logic        clock,
	input wire logic        cs_n,
	input wire logic        ras_n,
	input wire logic        cas_n,
	input wire logic        we_n,
	input wire logic [12:0] addr,
	input wire logic [1:0]  ba,
	input wire logic        cke
);
	int          n_pre = 0;
	int          n_ref = 0;
	int          n_lmr = 0;
	logic [12:0] mode = 13'h0;
	logic [12:0] ext = 13'h0;
	// commands with clock enable low are lost, as on a real part
	always @(posedge clock) begin
		if (cke === 1'b1) begin
			case ({cs_n, ras_n, cas_n, we_n})
				CMD_PRE: n_pre++;
				CMD_REF: n_ref++;
				CMD_LMR: begin
					n_lmr++;
					if (ba == 2'h2) ext = addr;
					else mode = addr;
				end
				default: ;
			endcase
		end
	end
endmodule

// ==== tb.sv ====
// testbench for sirc_ctrl: register tasks, init and refresh scenarios
// assumes sirc_mem_model on the memory pins; access sequencer levels driven here
`timescale 1ns/1ps
module tb;
	logic        clock = 1'b0;
	logic        nrst = 1'b0;
	logic [2:0]  address = 3'h0;
	logic        read = 1'b0;
	logic        write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [3:0]  byteenable = 4'h0;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        access_busy = 1'b0;
	logic        req_pending = 1'b1;
	logic        rd_pending = 1'b0;
	logic        any_bank_open = 1'b1;
	logic        access_allow;
	logic        mem_cs_n;
	logic        mem_ras_n;
	logic        mem_cas_n;
	logic        mem_we_n;
	logic [12:0] memory_address_pins;
	logic [1:0]  memory_bank_pins;
	logic        memory_clock_enable_pin;
	int          n_fail = 0;
	int          total_checks = 0;
	int          p;
	int          r;
	int          l;
	logic [31:0] q;

	always #10 clock = ~clock;

	sirc_ctrl i_sirc_ctrl (.clock, .nrst, .address, .read, .write, .writedata, .byteenable,
		.readdata, .waitrequest, .access_busy, .req_pending, .rd_pending, .any_bank_open,
		.access_allow, .mem_cs_n, .mem_ras_n, .mem_cas_n, .mem_we_n, .memory_address_pins,
		.memory_bank_pins, .memory_clock_enable_pin);
	sirc_mem_model i_sirc_mem_model (.clock, .cs_n(mem_cs_n), .ras_n(mem_ras_n),
		.cas_n(mem_cas_n), .we_n(mem_we_n), .addr(memory_address_pins),
		.ba(memory_bank_pins), .cke(memory_clock_enable_pin));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	// request held until waitrequest is seen low at a rising edge
	task bus(input logic w, input logic [2:0] a, input logic [31:0] d, input logic [3:0] be);
		int k;
		k = 0;
		@(posedge clock);
		read <= !w;
		write <= w;
		address <= a;
		writedata <= d;
		byteenable <= be;
		do begin
			@(posedge clock);
			k++;
		end while (waitrequest !== 1'b0 && k < 50);
		if (k >= 50) chk("waitrequest", 32'h0, 32'h1);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task rdc(input string nm, input logic [2:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0, 4'h0);
		chk(nm, q, exp);
	endtask

	task wait_allow;
		int k;
		k = 0;
		while (access_allow === 1'b1 && k < 8) begin
			@(negedge clock);
			k++;
		end
		k = 0;
		while (access_allow !== 1'b1 && k < 5000) begin
			@(negedge clock);
			k++;
		end
		if (k >= 5000) chk("allow", 32'h0, 32'h1);
	endtask

	task snap;
		p = i_sirc_mem_model.n_pre;
		r = i_sirc_mem_model.n_ref;
		l = i_sirc_mem_model.n_lmr;
	endtask

	task cnt_chk(input int ep, input int er, input int el);
		chk("pre", i_sirc_mem_model.n_pre - p, ep);
		chk("ref", i_sirc_mem_model.n_ref - r, er);
		chk("lmr", i_sirc_mem_model.n_lmr - l, el);
	endtask

	task end_of_test;
		if (n_fail == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		repeat (30000) @(posedge clock);
		chk("watchdog", 32'h0, 32'h1);
		end_of_test;
	end

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge clock);
		nrst <= 1'b1;
		rdc("main_rst", 3'h0, 32'h0001_0600);
		rdc("rfc_rst", 3'h1, 32'h0000_0100);
		rdc("tim1_rst", 3'h2, 32'h0000_0083);
		bus(1'b1, 3'h7, 32'hffff_ffff, 4'hf);
		rdc("unmapped", 3'h7, 32'h0);
		bus(1'b1, 3'h2, 32'h0000_0083, 4'hf);
		bus(1'b1, 3'h1, 32'h0000_0040, 4'hf);
		snap;
		bus(1'b1, 3'h0, 32'h0001_0400, 4'hf);
		wait_allow;
		cnt_chk(3, 9, 1);
		chk("mode", {19'h0, i_sirc_mem_model.mode}, 32'h22);
		// low-power type, restarted mid-sequence by the second config write
		any_bank_open <= 1'b0;
		req_pending <= 1'b0;
		repeat (300) @(posedge clock);
		access_busy <= 1'b1;
		wait_allow;
		snap;
		bus(1'b1, 3'h0, 32'h0003_4600, 4'hf);
		bus(1'b1, 3'h4, 32'h0000_0005, 4'h1);
		wait_allow;
		cnt_chk(2, 9, 2);
		chk("ext", {19'h0, i_sirc_mem_model.ext}, 32'h5);
		chk("mode", {19'h0, i_sirc_mem_model.mode}, 32'h33);
		snap;
		bus(1'b1, 3'h0, 32'h0003_4600, 4'h4);
		repeat (300) @(posedge clock);
		chk("lmr", i_sirc_mem_model.n_lmr - l, 0);
		// backlog saturation and urgency levels
		bus(1'b1, 3'h1, 32'h8000_0040, 4'hf);
		rd_pending <= 1'b1;
		repeat (50) @(posedge clock);
		snap;
		repeat (1100) @(posedge clock);
		rdc("status_sat", 3'h5, 32'h20f);
		chk("status", q & 32'h60f, 32'h20f);
		chk("ref_busy", i_sirc_mem_model.n_ref - r, 0);
		access_busy <= 1'b0;
		wait_allow;
		bus(1'b0, 3'h5, 32'h0, 4'h0);
		chk("must_end", {30'h0, q[3:2]}, 32'h1);
		chk("must_refs", {31'h0, i_sirc_mem_model.n_ref - r >= 8}, 32'h1);
		bus(1'b1, 3'h1, 32'h0000_1fff, 4'h3);
		rd_pending <= 1'b0;
		any_bank_open <= 1'b1;
		repeat (300) @(posedge clock);
		bus(1'b0, 3'h5, 32'h0, 4'h0);
		chk("bl_open", {28'h0, q[3:0]}, 32'h3);
		any_bank_open <= 1'b0;
		repeat (300) @(posedge clock);
		bus(1'b0, 3'h5, 32'h0, 4'h0);
		chk("bl_idle", {28'h0, q[3:0]}, 32'h0);
		end_of_test;
	end
endmodule
